// *** hdl/svs_map.svh ***
`ifndef SVS_MAP_SVH
`define SVS_MAP_SVH
// ***********************************************
// Register addresses
// ***********************************************
`define SVS_ADDR_CONTROL 16'hFFBE
`define SVS_ADDR_LEVEL 16'hFFBF
// ***********************************************
// Register fields and values
// ***********************************************
`define SVS_BIT_CMP_EN 7
`define SVS_BIT_REF_EN 4
`define SVS_BIT_MODE 1
`define SVS_BIT_FLAG 0
`define SVS_RESET_CONTROL 8'h00
`define SVS_RESET_LEVEL 8'h00
`define SVS_RESET_CAUSE 8'h00
`define SVS_LEVEL_PROHIBITED 3'h7
`define SVS_CAUSE_BIT_UV 0
// ***********************************************
// Timing
// ***********************************************
`define SVS_POWERUP_NS 1000
`define SVS_CLK_NS 50
`define SVS_POWERUP_CYCLES ((`SVS_POWERUP_NS + `SVS_CLK_NS - 1) / `SVS_CLK_NS)
`endif

// *** hdl/svs_pkg.sv ***
package svs_pkg;
   // Power-on supervisor option
   typedef enum logic [1:0] {
      SVS_POC_OFF = 2'h0,
      SVS_POC_LOW = 2'h1,
      SVS_POC_HIGH = 2'h2
   } svs_poc_type;
   // Reset sources other than power-on
   typedef enum logic [2:0] {
      SVS_SRC_WDT = 3'h1,
      SVS_SRC_UV = 3'h2,
      SVS_SRC_CLK = 3'h4
   } svs_src_type;
endpackage

// *** hdl/svs_sync.sv ***
`timescale 1ns/1ps
// ***********************************************
// Two-flop synchroniser bank
// ***********************************************
module svs_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] meta_q;
   // First stage read only by the second
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q <= '0;
         syncOut <= '0;
      end else begin
         meta_q <= asyncIn;
         syncOut <= meta_q;
      end
   end
endmodule

// *** hdl/supply_voltage_supervisor.sv ***
`timescale 1ns/1ps
`include "svs_map.svh"
// What this block does
// - At power-up the supervisor asserts the chip-wide internal reset.
// - Internal reset held while the power-on comparator shows supply below threshold.
// - Fixed option selects supervisor disabled, lower threshold or higher threshold.
// - A power-on supervisor reset clears the whole reset-cause register.
// - Watchdog, detector, clock-monitor resets only set their own cause flag.
// - A detector reset sets bit 0 of the reset-cause register.
// - Software picks one of seven detection levels; reduced grades offer five.
// - Detector keeps working and raising events in STOP mode.
// - Control fields: comparator enable 7, reference enable 4, mode 1, flag 0.
// - Control register at its address, resets to zero, bit and byte writes.
// - Detection flag is read-only; writes leave it alone.
// - Comparator enable starts the comparator; clearing it disables detection.
// - Reference enable switches the reference generator on or off.
// - Mode bit: zero gives interrupt, one gives internal reset on undervoltage.
// - Flag is one below threshold, zero above or when disabled.
// - Non-detector resets clear control bits; detector reset keeps them.
// - With supervisor used, reference runs always and reference enable is ignored.
// - Flag drives the interrupt only with comparator enabled and mode zero.
// - Level register holds a 3-bit code; 111 prohibited, upper bits zero.
module supply_voltage_supervisor
   import svs_pkg::*;
#(
   parameter int LEVEL_COUNT = 7,
   parameter int POWERUP_CYCLES = `SVS_POWERUP_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire svs_poc_type pocOption,
   input wire logic pocBelow,
   input wire logic uvBelow,
   input wire logic wdtReset,
   input wire logic clkMonReset,
   input wire logic [15:0] busAddr,
   input wire logic [7:0] busWdata,
   input wire logic busWrite,
   input wire logic busBitWrite,
   input wire logic [2:0] busBitSel,
   input wire logic busRead,
   output logic [7:0] busRdata,
   output logic [2:0] detectLevelSelect,
   output logic comparatorOn,
   output logic referenceOn,
   output logic undervoltageIrq,
   output logic internalReset,
   output logic [7:0] resetCause
);
   // ***********************************************
   // Input synchronisation
   // ***********************************************
   logic [3:0] rawIn;
   logic [3:0] syncIn;
   logic pocLow;
   logic uvLow;
   logic wdtEv;
   logic clkEv;
   assign rawIn = {clkMonReset, wdtReset, uvBelow, pocBelow};
   svs_sync #(.WIDTH(4)) u_sync (
      .clk(clk),
      .rst(rst),
      .asyncIn(rawIn),
      .syncOut(syncIn)
   );
   assign pocLow = syncIn[0];
   assign uvLow = syncIn[1];
   assign wdtEv = syncIn[2];
   assign clkEv = syncIn[3];

   // ***********************************************
   // Power-on supervisor
   // ***********************************************
   logic [15:0] pwrCnt_q;
   logic [15:0] pwrCnt_d;
   logic pocUsed;
   logic pocTrip;
   logic pwrUp;
   // Option decode; disabled ignores the comparator
   assign pocUsed = (pocOption == SVS_POC_LOW) || (pocOption == SVS_POC_HIGH);
   assign pwrUp = (pwrCnt_q != 16'h0000);
   assign pocTrip = pwrUp || (pocUsed && pocLow);
   assign pwrCnt_d = pwrUp ? pwrCnt_q - 16'h0001 : 16'h0000;
   // Power-up stretch, reloaded by the rst pin
   always_ff @(posedge clk) begin
      if (rst) begin
         pwrCnt_q <= 16'(POWERUP_CYCLES);
      end else begin
         pwrCnt_q <= pwrCnt_d;
      end
   end

   // ***********************************************
   // Register writes
   // ***********************************************
   logic selCtl;
   logic selLvl;
   logic [7:0] ctlWr;
   logic [7:0] ctlMerge;
   logic cmpEn_q;
   logic refEn_q;
   logic mode_q;
   logic [2:0] level_q;
   logic [2:0] levelWr;
   logic levelOk;
   assign selCtl = (busAddr == `SVS_ADDR_CONTROL);
   assign selLvl = (busAddr == `SVS_ADDR_LEVEL);
   // Bit write merges one bit into current value
   assign ctlMerge = {cmpEn_q, 2'h0, refEn_q, 2'h0, mode_q, 1'b0};
   assign ctlWr = busBitWrite ? ((ctlMerge & ~(8'h01 << busBitSel)) | ({7'h00, busWdata[0]} << busBitSel))
                              : busWdata;
   assign levelWr = busWdata[2:0];
   assign levelOk = (levelWr != `SVS_LEVEL_PROHIBITED) && (32'(levelWr) < LEVEL_COUNT);

   // ***********************************************
   // Detector core
   // ***********************************************
   logic refActive;
   logic flag;
   logic uvTrip;
   logic otherReset;
   // Reference forced on while the supervisor is in use
   assign refActive = pocUsed || refEn_q;
   // Comparator needs enable and reference; no clock gating so STOP has no effect
   assign flag = cmpEn_q && refActive && uvLow;
   assign uvTrip = cmpEn_q && mode_q && flag;
   assign otherReset = pocTrip || wdtEv || clkEv;

   // Control bits survive only the detector reset
   always_ff @(posedge clk) begin
      if (rst || otherReset) begin
         cmpEn_q <= 1'b0;
         refEn_q <= 1'b0;
         mode_q <= 1'b0;
      end else if (selCtl && (busWrite || busBitWrite)) begin
         cmpEn_q <= ctlWr[`SVS_BIT_CMP_EN];
         refEn_q <= ctlWr[`SVS_BIT_REF_EN];
         mode_q <= ctlWr[`SVS_BIT_MODE];
      end
   end

   // Level register, byte writes only
   always_ff @(posedge clk) begin
      if (rst || otherReset) begin
         level_q <= 3'h0;
      end else if (selLvl && busWrite && levelOk) begin
         level_q <= levelWr;
      end
   end

   // ***********************************************
   // Reset cause
   // ***********************************************
   logic [7:0] cause_q;
   logic [7:0] cause_d;
   // Power-on clears all, others set own flag
   always_comb begin
      cause_d = cause_q;
      if (pocTrip) begin
         cause_d = `SVS_RESET_CAUSE;
      end else begin
         if (uvTrip) begin
            cause_d[`SVS_CAUSE_BIT_UV] = 1'b1;
         end
         if (wdtEv) begin
            cause_d[4] = 1'b1;
         end
         if (clkEv) begin
            cause_d[1] = 1'b1;
         end
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         cause_q <= `SVS_RESET_CAUSE;
      end else begin
         cause_q <= cause_d;
      end
   end

   // ***********************************************
   // Outputs
   // ***********************************************
   logic [7:0] rdMux;
   assign rdMux = selCtl ? {cmpEn_q, 2'h0, refEn_q, 2'h0, mode_q, flag}
                : selLvl ? {5'h00, level_q} : 8'h00;
   always_ff @(posedge clk) begin
      if (rst) begin
         busRdata <= 8'h00;
         detectLevelSelect <= 3'h0;
         comparatorOn <= 1'b0;
         referenceOn <= 1'b0;
         undervoltageIrq <= 1'b0;
         internalReset <= 1'b1;
         resetCause <= 8'h00;
      end else begin
         busRdata <= busRead ? rdMux : 8'h00;
         detectLevelSelect <= level_q;
         comparatorOn <= cmpEn_q;
         referenceOn <= refActive;
         undervoltageIrq <= cmpEn_q && !mode_q && flag;
         internalReset <= pocTrip || uvTrip || wdtEv || clkEv;
         resetCause <= cause_d;
      end
   end

   // ***********************************************
   // Checks
   // ***********************************************
   power_on_hold_a: assert property (@(posedge clk) disable iff (rst)
      (pocUsed && pocLow) |=> internalReset)
      else $error("reset not held for low supply");
   poc_clear_a: assert property (@(posedge clk) disable iff (rst)
      pocTrip |=> (resetCause == 8'h00))
      else $error("power-on did not clear cause");
   uv_cause_a: assert property (@(posedge clk) disable iff (rst)
      (uvTrip && !pocTrip) |=> resetCause[0])
      else $error("detector cause not set");
   irq_gate_a: assert property (@(posedge clk) disable iff (rst)
      undervoltageIrq |-> ($past(cmpEn_q) && !$past(mode_q)))
      else $error("irq outside interrupt mode");
   flag_off_a: assert property (@(posedge clk) disable iff (rst)
      !cmpEn_q |-> !flag)
      else $error("flag set while disabled");
   keep_bits_a: assert property (@(posedge clk) disable iff (rst)
      (uvTrip && !otherReset && !busWrite && !busBitWrite) |=> (cmpEn_q && mode_q))
      else $error("detector reset lost control bits");
   clear_bits_a: assert property (@(posedge clk) disable iff (rst)
      otherReset |=> (!cmpEn_q && !refEn_q && !mode_q))
      else $error("control bits not cleared");
   ref_forced_a: assert property (@(posedge clk) disable iff (rst)
      pocUsed |=> referenceOn)
      else $error("reference not forced on");
   level_legal_a: assert property (@(posedge clk) disable iff (rst)
      level_q != 3'h7)
      else $error("prohibited level stored");
   uv_reset_a: assert property (@(posedge clk) disable iff (rst)
      (internalReset && !$past(pocTrip) && !$past(wdtEv) && !$past(clkEv)) |-> $past(uvTrip))
      else $error("spurious internal reset");
   irq_follow_a: assert property (@(posedge clk) disable iff (rst)
      (cmpEn_q && !mode_q && flag) |=> undervoltageIrq)
      else $error("irq missing in interrupt mode");
   cmp_out_a: assert property (@(posedge clk) disable iff (rst)
      comparatorOn == $past(cmpEn_q))
      else $error("comparator output lags enable");
   level_out_a: assert property (@(posedge clk) disable iff (rst)
      detectLevelSelect == $past(level_q))
      else $error("level output lags register");
   ref_off_a: assert property (@(posedge clk) disable iff (rst)
      (!pocUsed && !refEn_q) |=> !referenceOn)
      else $error("reference on while disabled");
   wdt_cause_a: assert property (@(posedge clk) disable iff (rst)
      (wdtEv && !pocTrip) |=> resetCause[4])
      else $error("watchdog cause not set");
   clk_cause_a: assert property (@(posedge clk) disable iff (rst)
      (clkEv && !pocTrip) |=> resetCause[1])
      else $error("clock monitor cause not set");
   pwr_stretch_a: assert property (@(posedge clk) disable iff (rst)
      pwrUp |=> internalReset)
      else $error("power-up stretch without reset");
   uv_reset_on_a: assert property (@(posedge clk) disable iff (rst)
      uvTrip |=> internalReset)
      else $error("detector reset not raised");
   read_idle_a: assert property (@(posedge clk) disable iff (rst)
      !busRead |=> (busRdata == 8'h00))
      else $error("read data without strobe");
endmodule

// *** tb/svs_analog_model.sv ***
`timescale 1ns/1ps
// ***********************************************
// Analog comparators facing the supervisor
// ***********************************************
module svs_analog_model
   import svs_pkg::*;
(
   input int supplyMv,
   input wire svs_poc_type pocOption,
   input wire logic [2:0] detectLevelSelect,
   input wire logic comparatorOn,
   input wire logic referenceOn,
   output logic pocBelow,
   output logic uvBelow
);
   int pocMv;
   int uvMv;
   // Thresholds from strap and level code, then the two compares
   always_comb begin
      pocMv = (pocOption == SVS_POC_HIGH) ? 3500 : (pocOption == SVS_POC_LOW) ? 2850 : 0;
      uvMv = 4300 - 200 * int'(detectLevelSelect);
      pocBelow = supplyMv < pocMv;
      uvBelow = comparatorOn && referenceOn && supplyMv < uvMv;
   end
endmodule

// *** tb/test_supply_voltage_supervisor.sv ***
`timescale 1ns/1ps
`include "svs_map.svh"
module test_supply_voltage_supervisor
   import svs_pkg::*;
;
   // ***********************************************
   // Stimulus and observed signals
   // ***********************************************
   logic clk = 1'h0;
   logic rst = 1'h1;
   svs_poc_type pocOption = SVS_POC_OFF;
   logic pocBelow, uvBelow;
   logic wdtReset = 1'h0;
   logic clkMonReset = 1'h0;
   logic [15:0] busAddr = 16'h0000;
   logic [7:0] busWdata = 8'h00;
   logic busWrite = 1'h0;
   logic busBitWrite = 1'h0;
   logic [2:0] busBitSel = 3'h0;
   logic busRead = 1'h0;
   logic [7:0] busRdata, resetCause;
   logic [2:0] detectLevelSelect;
   logic comparatorOn, referenceOn, undervoltageIrq, internalReset;
   int supplyMv = 5000;
   int fails = 0;
   int num_checks = 0;
   int lvl = 0;
   logic [7:0] seed = 8'h58;
   svs_poc_type opts[$] = '{SVS_POC_OFF, SVS_POC_LOW, SVS_POC_HIGH};

   // Clock, 50 ns period
   always #25 clk = ~clk;

   supply_voltage_supervisor #(.LEVEL_COUNT(7), .POWERUP_CYCLES(4)) uut (.clk(clk), .rst(rst),
      .pocOption(pocOption), .pocBelow(pocBelow), .uvBelow(uvBelow), .wdtReset(wdtReset),
      .clkMonReset(clkMonReset), .busAddr(busAddr), .busWdata(busWdata), .busWrite(busWrite),
      .busBitWrite(busBitWrite), .busBitSel(busBitSel), .busRead(busRead), .busRdata(busRdata),
      .detectLevelSelect(detectLevelSelect), .comparatorOn(comparatorOn), .referenceOn(referenceOn),
      .undervoltageIrq(undervoltageIrq), .internalReset(internalReset), .resetCause(resetCause));

   svs_analog_model partner (.supplyMv(supplyMv), .pocOption(pocOption),
      .detectLevelSelect(detectLevelSelect), .comparatorOn(comparatorOn), .referenceOn(referenceOn),
      .pocBelow(pocBelow), .uvBelow(uvBelow));

   // ***********************************************
   // Compare, bus and wait helpers
   // ***********************************************
   task automatic test_done();
      $display("checks %0d, mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
      end
   endtask
   task automatic chkBit(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: bit %b, wanted %b", $time, got, exp);
      end
   endtask
   task automatic waitRst(input logic v);
      for (int n = 0; n < 200 && internalReset !== v; n++) @(posedge clk) #1;
      if (internalReset !== v) begin
         fails++;
         $display("unexpected at %0t: reset wait ran out", $time);
         test_done();
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      busAddr <= a;
      busWdata <= d;
      busWrite <= 1'h1;
      @(posedge clk);
      busWrite <= 1'h0;
      #1;
   endtask
   task automatic bwr(input logic [2:0] b, input logic v);
      @(posedge clk);
      busAddr <= `SVS_ADDR_CONTROL;
      busBitSel <= b;
      busWdata <= {7'h00, v};
      busBitWrite <= 1'h1;
      @(posedge clk);
      busBitWrite <= 1'h0;
      #1;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge clk);
      busAddr <= a;
      busRead <= 1'h1;
      @(posedge clk);
      busRead <= 1'h0;
      #1;
      chkByte(busRdata, e);
   endtask
   task automatic pulse(input bit wdt);
      @(posedge clk);
      if (wdt) wdtReset <= 1'h1;
      else clkMonReset <= 1'h1;
      repeat (2) @(posedge clk);
      wdtReset <= 1'h0;
      clkMonReset <= 1'h0;
      waitRst(1'h1);
      waitRst(1'h0);
   endtask
   function automatic logic [7:0] lfsr(input logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction

   // ***********************************************
   // Main sequence
   // ***********************************************
   initial begin
      int v;
      repeat (10) @(posedge clk);
      #1 chkBit(internalReset, 1'h1);
      @(posedge clk) rst <= 1'h0;
      waitRst(1'h0);
      chkByte(resetCause, 8'h00);
      rd(`SVS_ADDR_CONTROL, 8'h00);
      rd(`SVS_ADDR_LEVEL, 8'h00);
      rd(16'h1234, 8'h00);
      for (int i = 0; i < 9; i++) begin
         seed = lfsr(seed);
         v = (i == 8) ? 7 : int'(seed[2:0]);
         wr(`SVS_ADDR_LEVEL, 8'(v));
         if (v < 7) lvl = v;
         rd(`SVS_ADDR_LEVEL, 8'(lvl));
         chkByte({5'h00, detectLevelSelect}, 8'(lvl));
      end
      wr(`SVS_ADDR_LEVEL, 8'h00);
      wr(`SVS_ADDR_CONTROL, 8'h10);
      repeat (40000) @(posedge clk);
      wr(`SVS_ADDR_CONTROL, 8'h91);
      repeat (4000) @(posedge clk);
      rd(`SVS_ADDR_CONTROL, 8'h90);
      chkBit(comparatorOn, 1'h1);
      bwr(3'h4, 1'h0);
      @(posedge clk) #1 chkBit(referenceOn, 1'h0);
      @(posedge clk) pocOption <= SVS_POC_LOW;
      repeat (3) @(posedge clk);
      #1 chkBit(referenceOn, 1'h1);
      @(posedge clk) supplyMv <= 4000;
      repeat (5) @(posedge clk);
      #1 chkBit(undervoltageIrq, 1'h1);
      chkBit(internalReset, 1'h0);
      rd(`SVS_ADDR_CONTROL, 8'h81);
      bwr(3'h1, 1'h1);
      waitRst(1'h1);
      chkByte(resetCause, 8'h01);
      chkBit(undervoltageIrq, 1'h0);
      @(posedge clk) supplyMv <= 5000;
      waitRst(1'h0);
      rd(`SVS_ADDR_CONTROL, 8'h82);
      pulse(1'b1);
      chkByte(resetCause, 8'h11);
      rd(`SVS_ADDR_CONTROL, 8'h00);
      pulse(1'b0);
      chkByte(resetCause, 8'h13);
      foreach (opts[i]) begin
         @(posedge clk) pocOption <= opts[i];
         supplyMv <= 3000;
         repeat (8) @(posedge clk);
         #1 chkBit(internalReset, 1'(opts[i] == SVS_POC_HIGH));
         @(posedge clk) supplyMv <= 5000;
         waitRst(1'h0);
      end
      chkByte(resetCause, 8'h00);
      test_done();
   end
endmodule
